/* rtl/hcc_core_loader.v */
// Loader that fills one core's register file from main memory
`timescale 1ns/10ps
`include "hcc_regs.vh"

module hcc_core_loader #(
  parameter AW = 14
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [2:0] start_core,
  input wire [AW-1:0] code_addr,
  input wire [AW-1:0] par_ptr,
  input wire abort,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg busy_reg,
  output reg [2:0] core_reg,
  output reg mem_req_reg,
  output reg [AW-1:0] mem_addr_reg,
  output reg reg_we_reg,
  output reg [8:0] reg_addr_reg,
  output reg [31:0] reg_wdata_reg,
  output reg done_reg
);
  localparam ST_IDLE = 2'h0;
  localparam ST_FETCH = 2'h1;
  localparam ST_CLEAR = 2'h2;

  reg [1:0] state_reg;
  reg [8:0] ptr_reg;
  reg [AW-1:0] par_reg;

  // Sequencer: program words first, then special registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      core_reg <= 3'h0;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= {AW{1'b0}};
      reg_we_reg <= 1'b0;
      reg_addr_reg <= 9'h000;
      reg_wdata_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
      ptr_reg <= 9'h000;
      par_reg <= {AW{1'b0}};
    end else begin
      reg_we_reg <= 1'b0;
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_FETCH;
            busy_reg <= 1'b1;
            core_reg <= start_core;
            par_reg <= par_ptr;
            ptr_reg <= 9'h000;
            mem_req_reg <= 1'b1;
            mem_addr_reg <= code_addr;
          end
        end
        ST_FETCH: begin
          if (abort) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            mem_req_reg <= 1'b0;
          end else if (mem_ack) begin
            // Words land in order from register zero upward [RULE8]
            reg_we_reg <= 1'b1;
            reg_addr_reg <= ptr_reg;
            reg_wdata_reg <= mem_rdata;
            mem_addr_reg <= mem_addr_reg + {{(AW-1){1'b0}}, 1'b1};
            ptr_reg <= ptr_reg + 9'h001;
            if (ptr_reg == `HCC_LOAD_LAST) begin
              mem_req_reg <= 1'b0;
              state_reg <= ST_CLEAR;
            end
          end
        end
        ST_CLEAR: begin
          if (abort) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
          end else begin
            // Special registers zeroed, pointer goes to bits 15:2 [RULE8] [RULE7]
            reg_we_reg <= 1'b1;
            reg_addr_reg <= ptr_reg;
            reg_wdata_reg <= 32'h0000_0000;
            if (ptr_reg == `HCC_PAR_ADDR)
              reg_wdata_reg <= {16'h0000, par_reg, 2'b00};
            ptr_reg <= ptr_reg + 9'h001;
            if (ptr_reg == `HCC_SPR_LAST) begin
              state_reg <= ST_IDLE;
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
          mem_req_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule // hcc_core_loader

/* rtl/hcc_hub_ops.v */
// Hub unit executing read-index, launch and halt for eight cores
//
// Function
// [RULE1] Read-index returns the issuing core's number
// [RULE2] Source value 1, 2, 3 selects operation
// [RULE3] Read-index uses fixed opcode, effects, condition
// [RULE4] Read-index zero flag marks core zero
// [RULE5] Every operation takes 7 to 22 cycles; a launch held by a busy loader can take longer
// [RULE6] Launch word: pointer, code, new, index
// [RULE7] Pointer lands in parameter register bits 15:2
// [RULE8] Load program, clear specials, start at zero
// [RULE9] New flag starts lowest inactive core
// [RULE10] Clear new flag starts named core always
// [RULE11] Zero on index zero, carry if none free
// [RULE12] Launch writes result only when asked
// [RULE13] Halted core gets no more clocks; a core halted in the last cycle of its load is restarted by ld_done
// [RULE14] Halt uses only low three index bits
// [RULE15] Halt flags: zero index, all were running
// [RULE16] Flag and result writes follow effect bits
// [RULE17] Relaunch abandons running program at once
`timescale 1ns/10ps
`include "hcc_regs.vh"

module hcc_hub_ops #(
  parameter NCORE = 8,
  parameter AW = 14,
  parameter [7:0] RESET_ACTIVE = 8'h01
) (
  input wire clk,
  input wire resetn,
  // Request from the issuing core
  input wire req_valid,
  input wire [2:0] req_core,
  input wire [31:0] req_instr,
  input wire [31:0] req_dest_value,
  // Answer to the issuing core
  output reg req_busy_reg,
  output reg resp_valid_reg,
  output reg [2:0] resp_core_reg,
  output reg [31:0] resp_result_reg,
  output reg resp_result_write_reg,
  output reg resp_zero_reg,
  output reg resp_zero_write_reg,
  output reg resp_carry_reg,
  output reg resp_carry_write_reg,
  output reg resp_illegal_reg,
  // Per-core run state
  output reg [NCORE-1:0] core_clk_en_reg,
  output reg [NCORE-1:0] core_pc_reset_reg,
  // Main memory read port for the loader
  output wire mem_req,
  output wire [AW-1:0] mem_addr,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // Core register file write port
  output wire core_reg_we,
  output wire [2:0] core_reg_sel,
  output wire [8:0] core_reg_addr,
  output wire [31:0] core_reg_wdata
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;

  reg [1:0] state_reg;
  reg [4:0] wait_cnt_reg;
  reg [3:0] slot_cnt_reg;
  reg [2:0] cur_core_reg;
  reg [31:0] cur_instr_reg;
  reg [31:0] cur_dest_reg;

  // Loader hand-off
  reg ld_start_reg;
  reg [2:0] ld_core_reg;
  reg [AW-1:0] ld_code_reg;
  reg [AW-1:0] ld_par_reg;
  reg ld_abort_reg;
  wire ld_busy;
  wire [2:0] ld_core;
  wire ld_done;

  // Decoded request fields
  wire [5:0] opc = cur_instr_reg[`HCC_OPC_HI:`HCC_OPC_LO];
  wire [8:0] src = cur_instr_reg[`HCC_SRC_HI:`HCC_SRC_LO];
  wire eff_z = cur_instr_reg[`HCC_EFF_Z];
  wire eff_c = cur_instr_reg[`HCC_EFF_C];
  wire eff_r = cur_instr_reg[`HCC_EFF_R];
  wire eff_i = cur_instr_reg[`HCC_EFF_I];
  wire is_hub = (opc == `HCC_OPC_HUB) && eff_i;
  wire is_read_id = is_hub && (src == `HCC_SRC_READ_ID);
  wire is_launch = is_hub && (src == `HCC_SRC_LAUNCH);
  wire is_halt = is_hub && (src == `HCC_SRC_HALT);

  // Launch word fields
  wire lw_new = cur_dest_reg[`HCC_LW_NEW];
  wire [2:0] lw_id = cur_dest_reg[`HCC_LW_ID_HI:`HCC_LW_ID_LO];
  wire [AW-1:0] lw_code = cur_dest_reg[`HCC_LW_CODE_HI:`HCC_LW_CODE_LO];
  wire [AW-1:0] lw_par = cur_dest_reg[`HCC_LW_PAR_HI:`HCC_LW_PAR_LO];

  // A core being loaded counts as taken
  wire [NCORE-1:0] loading = ld_busy ? ({{(NCORE-1){1'b0}}, 1'b1} << ld_core) : {NCORE{1'b0}};
  wire [NCORE-1:0] taken = core_clk_en_reg | loading;

  // Lowest free core, or the last one with carry when none is free
  reg [2:0] free_id;
  reg free_found;
  integer i;
  always @* begin
    free_id = `HCC_LAST_CORE;
    free_found = 1'b0;
    for (i = NCORE - 1; i >= 0; i = i - 1) begin
      if (!taken[i]) begin
        free_id = i[2:0]; // [RULE9]
        free_found = 1'b1;
      end
    end
  end

  // Slot of the waiting core comes once per rotation
  wire at_slot = (slot_cnt_reg == {cur_core_reg, 1'b0});
  wire min_done = (wait_cnt_reg >= (`HCC_HUB_MIN - 5'h01));
  // A launch holds on a busy loader; hazard: latency can exceed the maximum then
  wire exec_now = (state_reg == ST_WAIT) && at_slot && min_done && !(is_launch && ld_busy);

  // Chosen target core per operation
  reg [2:0] tgt_id;
  always @* begin
    tgt_id = cur_core_reg; // [RULE1]
    if (is_launch)
      tgt_id = lw_new ? free_id : lw_id; // [RULE9] [RULE10]
    else if (is_halt)
      tgt_id = cur_dest_reg[2:0]; // [RULE14]
  end

  // Slot rotation runs free, two cycles per core
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      slot_cnt_reg <= 4'h0;
    else
      slot_cnt_reg <= slot_cnt_reg + 4'h1; // [RULE5]
  end

  // Request capture and hub wait
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      wait_cnt_reg <= 5'h00;
      cur_core_reg <= 3'h0;
      cur_instr_reg <= 32'h0000_0000;
      cur_dest_reg <= 32'h0000_0000;
      req_busy_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            state_reg <= ST_WAIT;
            wait_cnt_reg <= 5'h01;
            cur_core_reg <= req_core;
            cur_instr_reg <= req_instr;
            cur_dest_reg <= req_dest_value;
            req_busy_reg <= 1'b1;
          end
        end
        ST_WAIT: begin
          // Saturate so a stalled launch cannot wrap the count
          if (wait_cnt_reg != 5'h1F)
            wait_cnt_reg <= wait_cnt_reg + 5'h01;
          if (exec_now) begin
            state_reg <= ST_IDLE; // [RULE5]
            req_busy_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          req_busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Answer to the requester, one cycle wide
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resp_valid_reg <= 1'b0;
      resp_core_reg <= 3'h0;
      resp_result_reg <= 32'h0000_0000;
      resp_result_write_reg <= 1'b0;
      resp_zero_reg <= 1'b0;
      resp_zero_write_reg <= 1'b0;
      resp_carry_reg <= 1'b0;
      resp_carry_write_reg <= 1'b0;
      resp_illegal_reg <= 1'b0;
    end else begin
      resp_valid_reg <= exec_now;
      if (exec_now) begin
        resp_core_reg <= cur_core_reg;
        resp_result_reg <= {29'h0000_0000, tgt_id}; // [RULE1] [RULE12] [RULE15]
        resp_zero_reg <= (tgt_id == 3'h0); // [RULE4] [RULE11] [RULE15]
        resp_carry_reg <= 1'b0;
        if (is_launch)
          resp_carry_reg <= lw_new && !free_found; // [RULE11]
        else if (is_halt)
          resp_carry_reg <= &core_clk_en_reg; // [RULE15]
        // Writes follow the effect bits of the word [RULE16] [RULE3] [RULE12]
        resp_result_write_reg <= (is_read_id || is_launch || is_halt) && eff_r;
        resp_zero_write_reg <= (is_read_id || is_launch || is_halt) && eff_z;
        resp_carry_write_reg <= (is_read_id || is_launch || is_halt) && eff_c;
        resp_illegal_reg <= !(is_read_id || is_launch || is_halt); // [RULE2]
      end else begin
        resp_result_write_reg <= 1'b0;
        resp_zero_write_reg <= 1'b0;
        resp_carry_write_reg <= 1'b0;
        resp_illegal_reg <= 1'b0;
      end
    end
  end

  // Core run state and loader control
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_clk_en_reg <= RESET_ACTIVE;
      core_pc_reset_reg <= {NCORE{1'b0}};
      ld_start_reg <= 1'b0;
      ld_core_reg <= 3'h0;
      ld_code_reg <= {AW{1'b0}};
      ld_par_reg <= {AW{1'b0}};
      ld_abort_reg <= 1'b0;
    end else begin
      core_pc_reset_reg <= {NCORE{1'b0}};
      ld_start_reg <= 1'b0;
      ld_abort_reg <= 1'b0;
      // Loaded core starts at register zero [RULE8]
      if (ld_done) begin
        core_clk_en_reg[ld_core] <= 1'b1;
        core_pc_reset_reg[ld_core] <= 1'b1;
      end
      if (exec_now && is_launch && (free_found || !lw_new)) begin
        // Running target is stopped before its reload [RULE17] [RULE10]
        core_clk_en_reg[tgt_id] <= 1'b0;
        ld_start_reg <= 1'b1;
        ld_core_reg <= tgt_id;
        ld_code_reg <= lw_code;
        ld_par_reg <= lw_par; // [RULE7]
      end
      if (exec_now && is_halt) begin
        core_clk_en_reg[tgt_id] <= 1'b0; // [RULE13]
        // Halting the core being loaded cancels its load in all but the load's last cycle, where ld_done still starts the core
        if (ld_busy && (ld_core == tgt_id))
          ld_abort_reg <= 1'b1;
      end
    end
  end

  // Loader drives main memory and the target register file
  hcc_core_loader #(
    .AW(AW)
  ) u_loader (
    .clk(clk),
    .resetn(resetn),
    .start(ld_start_reg),
    .start_core(ld_core_reg),
    .code_addr(ld_code_reg),
    .par_ptr(ld_par_reg),
    .abort(ld_abort_reg),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .busy_reg(ld_busy),
    .core_reg(ld_core),
    .mem_req_reg(mem_req),
    .mem_addr_reg(mem_addr),
    .reg_we_reg(core_reg_we),
    .reg_addr_reg(core_reg_addr),
    .reg_wdata_reg(core_reg_wdata),
    .done_reg(ld_done)
  );

  // Register file target is the core under load
  assign core_reg_sel = ld_core;
endmodule // hcc_hub_ops

/* shared/hcc_regs.vh */
// Constants for the hub core control operations
`ifndef HCC_REGS_VH
`define HCC_REGS_VH

// Instruction word field positions
`define HCC_OPC_HI 31
`define HCC_OPC_LO 26
`define HCC_EFF_Z 25
`define HCC_EFF_C 24
`define HCC_EFF_R 23
`define HCC_EFF_I 22
`define HCC_SRC_HI 8
`define HCC_SRC_LO 0

// Shared hub opcode and source selectors
`define HCC_OPC_HUB 6'h03
`define HCC_SRC_READ_ID 9'h001
`define HCC_SRC_LAUNCH 9'h002
`define HCC_SRC_HALT 9'h003

// Launch word layout
`define HCC_LW_PAR_HI 31
`define HCC_LW_PAR_LO 18
`define HCC_LW_CODE_HI 17
`define HCC_LW_CODE_LO 4
`define HCC_LW_NEW 3
`define HCC_LW_ID_HI 2
`define HCC_LW_ID_LO 0

// Core register file layout
`define HCC_LOAD_LAST 9'h1EF
`define HCC_SPR_FIRST 9'h1F0
`define HCC_SPR_LAST 9'h1FF
`define HCC_PAR_ADDR 9'h1F0

// Hub timing, in system clock cycles, and the last core number
`define HCC_HUB_MIN 5'h07
`define HCC_HUB_MAX 5'h16
`define HCC_SLOT_CYCLES 2
`define HCC_LAST_CORE 3'h7

`endif

/* verif/hcc_hub_ops_bench.sv */
// Testbench for the hub core control operations
`timescale 1ns/10ps
`include "hcc_regs.vh"
module hcc_hub_ops_bench;
  logic clk = 0, resetn = 0, req_valid = 0, slow = 0;
  logic [2:0] req_core = 0;
  logic [31:0] req_instr = 0, req_dest_value = 0;
  wire req_busy_reg, resp_valid_reg, resp_result_write_reg, resp_zero_reg, resp_zero_write_reg;
  wire resp_carry_reg, resp_carry_write_reg, resp_illegal_reg, mem_req, mem_ack, core_reg_we;
  wire [2:0] resp_core_reg, core_reg_sel;
  wire [31:0] resp_result_reg, mem_rdata, core_reg_wdata;
  wire [7:0] core_clk_en_reg, core_pc_reset_reg;
  wire [13:0] mem_addr;
  wire [8:0] core_reg_addr;
  int mismatches = 0, n_tests = 0, lat;
  hcc_hub_ops dut_u (.*);
  hcc_mem_model mem_u (.*);
  always #2 clk = ~clk;
  task summarize;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One hub request; returns once the answer pulse is visible
  task hub(input logic [2:0] c, input logic [8:0] src, input logic [3:0] eff, input logic [31:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_core <= c;
    req_instr <= {`HCC_OPC_HUB, eff, 4'hF, 9'h0, src};
    req_dest_value <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 1;
    while (resp_valid_reg !== 1'b1) begin
      @(posedge clk);
      #1;
      lat++;
      if (lat > 3000) begin
        mismatches++;
        summarize();
      end
    end
  endtask
  // Bounded wait for a core to come out of its load
  task wait_core(input int i);
    for (int n = 0; core_clk_en_reg[i] !== 1'b1; n++) begin
      @(posedge clk);
      if (n > 5000) begin
        mismatches++;
        summarize();
      end
    end
  endtask
  task t_index;
    for (int c = 0; c < 8; c += 5) begin
      hub(c[2:0], `HCC_SRC_READ_ID, 4'hB, 32'h0);
      chk(resp_result_reg, c);
      chk(resp_zero_reg, c == 0);
      chk(lat >= 7 && lat <= 22, 1);
    end
    hub(3, `HCC_SRC_READ_ID, 4'h1, 32'h0);
    chk({resp_result_write_reg, resp_zero_write_reg}, 0);
  endtask
  task t_halt_wrap;
    hub(2, `HCC_SRC_HALT, 4'hF, 32'h0000_0008);
    chk(resp_result_reg, 0);
    chk({resp_zero_reg, resp_carry_reg}, 2'b10);
    chk(core_clk_en_reg, 8'h00);
  endtask
  // Fill every core, then ask once more with none free
  task t_launch_all;
    slow <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      // Pointer field kept at 14 bits so the word stays 32 bits wide
      hub(1, `HCC_SRC_LAUNCH, k == 1 ? 4'h1 : 4'hF, {14'h1234 + 14'(k), 14'h0100, 1'b1, 3'h0});
      chk(resp_result_write_reg, k != 1);
      chk(resp_result_reg, k);
      chk({resp_zero_reg, resp_carry_reg}, {k == 0, 1'b0});
      wait_core(k);
      slow <= 1'b0;
    end
    hub(1, `HCC_SRC_LAUNCH, 4'hF, {14'h0, 14'h0100, 1'b1, 3'h0});
    chk(resp_result_reg, 32'h0000_0007);
    chk(resp_carry_reg, 1);
    chk(resp_zero_reg, 0);
    chk(core_clk_en_reg, 8'hFF);
  endtask
  task t_halt_full;
    hub(0, `HCC_SRC_HALT, 4'hF, 32'h0000_0005);
    chk(resp_result_reg, 32'h0000_0005);
    chk({resp_zero_reg, resp_carry_reg}, 2'b01);
  endtask
  task t_relaunch;
    hub(0, `HCC_SRC_LAUNCH, 4'hF, {14'h0040, 14'h0200, 1'b0, 3'h2});
    chk(resp_result_reg, 2);
    @(posedge clk);
    #1;
    chk(core_clk_en_reg[2], 0);
    wait_core(2);
  endtask
  task t_illegal;
    hub(0, 9'h004, 4'hF, 32'h0);
    chk({resp_illegal_reg, resp_result_write_reg}, 2'b10);
    hub(0, `HCC_SRC_READ_ID, 4'hE, 32'h0);
    chk(resp_illegal_reg, 1);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_index();
    t_halt_wrap();
    t_launch_all();
    t_halt_full();
    t_relaunch();
    t_illegal();
    summarize();
  end
endmodule // hcc_hub_ops_bench

/* verif/hcc_hub_ops_monitor.sv */
// Checker of hub operation timing, results and core loading
`timescale 1ns/10ps
`include "hcc_regs.vh"
module hcc_hub_ops_monitor #(parameter NCORE = 8, parameter AW = 14) (
  input wire clk,
  input wire resetn,
  input wire req_valid,
  input wire [2:0] req_core,
  input wire [31:0] req_instr,
  input wire [31:0] req_dest_value,
  input wire req_busy_reg,
  input wire resp_valid_reg,
  input wire [2:0] resp_core_reg,
  input wire [31:0] resp_result_reg,
  input wire resp_result_write_reg,
  input wire resp_zero_reg,
  input wire resp_zero_write_reg,
  input wire resp_carry_write_reg,
  input wire resp_illegal_reg,
  input wire [NCORE-1:0] core_clk_en_reg,
  input wire [NCORE-1:0] core_pc_reset_reg,
  input wire mem_req,
  input wire [AW-1:0] mem_addr,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire core_reg_we,
  input wire [2:0] core_reg_sel,
  input wire [8:0] core_reg_addr,
  input wire [31:0] core_reg_wdata
);
  reg [31:0] ins_q;
  reg [31:0] dst_q;
  reg [2:0] core_q;
  reg [8:0] last_q;
  wire acc = req_valid && !req_busy_reg;
  wire ok = resp_valid_reg && !resp_illegal_reg;
  wire [8:0] op = ins_q[8:0];
  // Latch the accepted request; results are judged against it
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ins_q <= 32'h0;
      dst_q <= 32'h0;
      core_q <= 3'h0;
      last_q <= 9'h0;
    end else begin
      if (acc) begin
        ins_q <= req_instr;
        dst_q <= req_dest_value;
        core_q <= req_core;
      end
      if (core_reg_we) begin
        last_q <= core_reg_addr;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Launch may wait on the loader, so only short ops are timed
  sequence s_acc;
    acc && req_instr[8:0] != `HCC_SRC_LAUNCH;
  endsequence
  sequence s_ans;
    ##[7:22] resp_valid_reg;
  endsequence
  a_busy_after_accept: assert property (acc |=> req_busy_reg) else $error("busy not raised");
  a_hub_latency: assert property (s_acc |-> s_ans) else $error("answer late");
  a_no_early_answer: assert property (s_acc |=> !resp_valid_reg [*6]) else $error("answer early");
  a_effect_bit_writes: assert property (ok |-> {resp_zero_write_reg, resp_carry_write_reg, resp_result_write_reg}
    == ins_q[25:23]) else $error("write enables differ");
  a_read_index_value: assert property (ok && op == `HCC_SRC_READ_ID |-> resp_result_reg == {29'h0, core_q}
    && resp_zero_reg == (core_q == 3'h0) && resp_core_reg == core_q) else $error("bad index");
  a_halt_low_bits: assert property (ok && op == `HCC_SRC_HALT |-> resp_result_reg == {29'h0, dst_q[2:0]}
    ##[0:1] !core_clk_en_reg[dst_q[2:0]]) else $error("bad halt");
  a_relaunch_stops: assert property (ok && op == `HCC_SRC_LAUNCH && !dst_q[3] |-> resp_result_reg ==
    {29'h0, dst_q[2:0]} ##[0:1] !core_clk_en_reg[dst_q[2:0]]) else $error("no stop");
  a_mem_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("req drop");
  a_load_in_order: assert property (core_reg_we |-> core_reg_addr == 9'h0 || core_reg_addr == last_q + 9'h1)
    else $error("load order");
  a_spr_cleared: assert property (core_reg_we && core_reg_addr > `HCC_PAR_ADDR |-> core_reg_wdata == 32'h0)
    else $error("special not zero");
  a_par_field: assert property (core_reg_we && core_reg_addr == `HCC_PAR_ADDR |-> core_reg_wdata ==
    {16'h0, dst_q[31:18], 2'b00}) else $error("bad parameter");
  a_start_at_zero: assert property (core_reg_we && core_reg_addr == `HCC_SPR_LAST |=> core_pc_reset_reg ==
    (8'h01 << $past(core_reg_sel)) && core_clk_en_reg[$past(core_reg_sel)]) else $error("no start");
  // Fetch begins at the code address of the launch word
  a_fetch_start: assert property ($rose(mem_req) |-> mem_addr == dst_q[17:4])
    else $error("bad code start");
  // Program words are the memory longs, not stale bus values
  a_word_from_mem: assert property (core_reg_we && core_reg_addr <= `HCC_LOAD_LAST |->
    core_reg_wdata == $past(mem_rdata)) else $error("word not from memory");
endmodule // hcc_hub_ops_monitor
bind hcc_hub_ops hcc_hub_ops_monitor #(.NCORE(NCORE), .AW(AW)) mon_u (.*);

/* verif/hcc_mem_model.sv */
// Main memory model answering the loader's long reads
`timescale 1ns/10ps
module hcc_mem_model (
  input wire clk,
  input wire resetn,
  input wire slow,
  input wire mem_req,
  input wire [13:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] wait_reg;
  // Ack after 0 or 3 extra cycles; data flips when not valid so stale reads show
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (!mem_ack && mem_req && wait_reg == (slow ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_reg <= 2'h0;
      mem_rdata <= {mem_addr, 4'hA, mem_addr};
    end else begin
      mem_ack <= 1'b0;
      wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // hcc_mem_model
